// ==== tb/sfsp_ctrl_tb.sv ====
// Self-checking bench for the status, protect and power-down control
`timescale 1ns/1ns
`include "sfsp_map.svh"
module sfsp_ctrl_tb;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_wp_n = 1'b1;
    logic i_array_busy = 1'b0;
    logic i_array_done = 1'b0;
    logic cs_n, sck, si, so, so_oe, sse_go, ce_go, pdown;
    logic [6:0] sector;
    logic [7:0] status;
    logic [31:0] rx;
    logic [7:0] pcode [6] = '{8'h04, 8'h08, 8'h0C, 8'h34, 8'h38, 8'h3C};
    logic [23:0] paddr [6] = '{24'h070000, 24'h060000, 24'h040000, 24'h00F000,
        24'h01F000, 24'h03F000};
    logic [23:0] faddr [6] = '{24'h06F000, 24'h05F000, 24'h03F000, 24'h010000,
        24'h020000, 24'h040000};
    int miscompares = 0;
    int cmp_count = 0;
    int sse_cnt = 0;
    int ce_cnt = 0;
    int oe_cnt = 0;
    always #4 i_mclk = ~i_mclk;
    sfsp_ctrl #(.WRSR_CYCLES(400), .SSE_CYCLES(40), .CE_CYCLES(60)) dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .i_array_busy(i_array_busy),
        .i_array_done(i_array_done), .o_sse_go(sse_go), .o_chip_erase_go(ce_go),
        .o_erase_sector(sector), .o_power_down(pdown), .o_status(status));
    sfsp_host_model host (.i_mclk(i_mclk), .i_so(so), .o_cs_n(cs_n), .o_sck(sck),
        .o_si(si));
    // Erase launches are single-cycle pulses, so count them
    always @(posedge i_mclk) begin
        if (sse_go === 1'b1) begin
            sse_cnt <= sse_cnt + 1;
        end
        if (ce_go === 1'b1) begin
            ce_cnt <= ce_cnt + 1;
        end
        if (so_oe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    // ***************************************
    // Checking and access tasks
    // ***************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Single-byte commands other than the status read never drive SO
    task automatic cmd(input logic [7:0] op);
        int n0;
        n0 = oe_cnt;
        host.xfer({24'h0, op}, 8, rx);
        check("so_oe_quiet", oe_cnt, n0);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (status[0] !== 1'b0 && n < 600) begin
            @(negedge i_mclk);
            n++;
        end
        if (n >= 600) begin
            miscompares++;
            finish_test();
        end
        // The latch clears one clock after busy drops
        repeat (2) @(negedge i_mclk);
    endtask
    // Two full status bytes follow the opcode in one frame
    task automatic rdsr(input logic [7:0] exp);
        int n0;
        n0 = oe_cnt;
        host.xfer({8'h00, `SFSP_OP_RDSR, 16'h0000}, 24, rx);
        check("status_read", rx[15:0], {exp, exp});
        check("so_oe_read", oe_cnt > n0, 1'b1);
        check("so_oe_idle", so_oe, 1'b0);
    endtask
    task automatic wrsr(input logic [7:0] v);
        cmd(`SFSP_OP_WREN);
        host.xfer({16'h0, `SFSP_OP_WRSR, v}, 16, rx);
        wait_ready();
    endtask
    // ***************************************
    // Main sequence
    // ***************************************
    initial begin
        int n;
        repeat (3) @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (8) @(negedge i_mclk);
        check("reset_status", status, 8'h00);
        rdsr(8'h00);
        cmd(`SFSP_OP_WREN);
        rdsr(8'h02);
        cmd(`SFSP_OP_WRDI);
        check("wel_clear", status, 8'h00);
        host.xfer({16'h0, `SFSP_OP_WRSR, 8'hFF}, 16, rx);
        check("wrsr_no_wel", status, 8'h00);
        cmd(`SFSP_OP_WREN);
        host.xfer({16'h0, `SFSP_OP_WRSR, 8'hFF}, 16, rx);
        check("busy_at_launch", status[0], 1'b1);
        rdsr(8'h03);
        cmd(`SFSP_OP_PDN);
        check("pd_while_busy", pdown, 1'b0);
        wait_ready();
        check("wrsr_done", status, 8'hBC);
        i_wp_n = 1'b0;
        cmd(`SFSP_OP_WREN);
        host.xfer({16'h0, `SFSP_OP_WRSR, 8'h00}, 16, rx);
        check("locked_ignored", status, 8'hBE);
        i_wp_n = 1'b1;
        host.xfer({16'h0, `SFSP_OP_WRSR, 8'h00}, 16, rx);
        wait_ready();
        check("unlocked_write", status, 8'h00);
        cmd(`SFSP_OP_WREN);
        host.xfer({17'h0, `SFSP_OP_WRSR, 7'h7F}, 15, rx);
        check("partial_byte", status, 8'h02);
        foreach (pcode[k]) begin
            wrsr(pcode[k]);
            cmd(`SFSP_OP_WREN);
            n = sse_cnt;
            host.xfer({`SFSP_OP_SSE_A, paddr[k]}, 32, rx);
            check("protected_erase", sse_cnt, n);
            check("wel_kept", status[1], 1'b1);
            host.xfer({`SFSP_OP_SSE_B, faddr[k] | 24'hF80000}, 32, rx);
            check("free_erase", sse_cnt, n + 1);
            check("sector", sector, faddr[k][18:12]);
            check("erase_busy", status[0], 1'b1);
            wait_ready();
            check("wel_after_erase", status, pcode[k]);
        end
        cmd(`SFSP_OP_WREN);
        cmd(`SFSP_OP_CE_A);
        check("ce_refused", ce_cnt, 0);
        wrsr(8'h10);
        cmd(`SFSP_OP_WREN);
        n = sse_cnt;
        host.xfer({`SFSP_OP_SSE_A, 24'h000000}, 32, rx);
        check("all_protected", sse_cnt, n);
        wrsr(8'h00);
        cmd(`SFSP_OP_WREN);
        cmd(`SFSP_OP_CE_B);
        check("ce_taken", ce_cnt, 1);
        wait_ready();
        i_array_busy = 1'b1;
        repeat (3) @(negedge i_mclk);
        check("array_busy", status[0], 1'b1);
        i_array_busy = 1'b0;
        cmd(`SFSP_OP_WREN);
        i_array_done = 1'b1;
        @(negedge i_mclk);
        i_array_done = 1'b0;
        repeat (3) @(negedge i_mclk);
        check("done_clears_wel", status, 8'h00);
        cmd(`SFSP_OP_PDN);
        check("pd_entry", pdown, 1'b1);
        cmd(`SFSP_OP_WREN);
        check("pd_refuses", status[1], 1'b0);
        cmd(`SFSP_OP_PDX);
        check("pd_exit", pdown, 1'b0);
        finish_test();
    end
endmodule

// ==== tb/sfsp_host_model.sv ====
// Host SPI controller model driving the serial pins in mode 0
`timescale 1ns/1ns
module sfsp_host_model (
    // Clock
    input wire logic i_mclk,
    // Serial pins
    input wire logic i_so,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // Half an SCK period of 32 ns is four mclk cycles
    task automatic half();
        repeat (4) @(negedge i_mclk);
    endtask
    // n bits MSB first; SO is taken mid high phase, after the synced fall
    task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] rx);
        rx = '0;
        @(negedge i_mclk);
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_si = d[i];
            half();
            o_sck = 1'b1;
            repeat (2) @(negedge i_mclk);
            rx = {rx[30:0], i_so};
            repeat (2) @(negedge i_mclk);
            o_sck = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        // Deselected: SI flips so stale data never looks valid
        o_si = ~o_si;
        repeat (8) @(negedge i_mclk);
    endtask
endmodule

// ==== verilog/sfsp_ctrl.sv ====
// SPI flash status, write-enable, power-down and small sector erase control
//
// Behaviour
// - status read drives bit 7 on the falling edge after the opcode's eighth bit
// - after bit 0 the status byte repeats from bit 7 while SCK runs
// - status read works during any erase, program or status write
// - status write is opcode plus one byte, started at chip select rise
// - only protect select, protect side and lock bits are writable
// - writable bits are nonvolatile, erased and rewritten internally
// - busy bit reads 1 during an internal write, 0 when done
// - latch at 0 refuses all writes; at 1 unprotected areas are writable
// - opcode 06h sets the write-enable latch, 04h clears it
// - latch clears at power-on and when any internal write completes
// - rejected writes and reads leave the latch unchanged
// - upper-side codes 001, 010, 011 protect from 070000h, 060000h, 040000h
// - lower-side codes 101, 110, 111 protect up to 00FFFFh, 01FFFFh, 03FFFFh
// - code 000 protects nothing; other top-bit codes protect all
// - chip erase runs only when all protect select bits are zero
// - lock bit set with write-protect low makes status writes ignored
// - opcode B9h enters power-down; only the ABh exit is then taken
// - power-down command during an internal write is ignored
// - a complete ABh byte leaves power-down
// - small sector erase is 20h or D7h plus address, sector from A18 to A12
// - small sector erase starts at chip select rise and ends on a timer
// - status byte holds side at bit 5, select at bits 4..2, lock at 7
// - write commands not ending on a whole byte are ignored
`timescale 1ns/1ns
`include "sfsp_map.svh"
module sfsp_ctrl import sfsp_pkg::*; #(
    parameter int unsigned WRSR_CYCLES = `SFSP_CYC(`SFSP_T_WRSR_US),
    parameter int unsigned SSE_CYCLES = `SFSP_CYC(`SFSP_T_SSE_US),
    parameter int unsigned CE_CYCLES = `SFSP_CYC(`SFSP_T_CE_US),
    parameter logic [4:0] NV_RESET = `SFSP_NV_RESET
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Serial pins
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    // Array side
    input wire logic i_array_busy,
    input wire logic i_array_done,
    output logic o_sse_go,
    output logic o_chip_erase_go,
    output logic [6:0] o_erase_sector,
    // State
    output logic o_power_down,
    output logic [7:0] o_status
);
    // ***************************************
    // Pin synchronisation
    // ***************************************
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    sfsp_pin_sync #(
        .W(4),
        .INIT(`SFSP_PIN_IDLE)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_pin({i_wp_n, i_si, i_sck, i_cs_n}),
        .o_level(pin_lvl),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    logic cs_act;
    logic cs_start;
    logic cs_end;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;
    logic wp_high;
    assign cs_act = ~pin_lvl[0];
    assign cs_start = pin_fall[0];
    assign cs_end = pin_rise[0];
    assign sck_rise = pin_rise[1] & cs_act;
    assign sck_fall = pin_fall[1] & cs_act;
    assign si_bit = pin_lvl[2];
    assign wp_high = pin_lvl[3];

    // ***************************************
    // Write engine
    // ***************************************
    sfsp_eng_if eng_bus();

    sfsp_wr_engine #(
        .WRSR_CYCLES(WRSR_CYCLES),
        .SSE_CYCLES(SSE_CYCLES),
        .CE_CYCLES(CE_CYCLES),
        .NV_RESET(NV_RESET)
    ) u_engine (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .bus(eng_bus)
    );

    // ***************************************
    // Frame tracking
    // ***************************************
    logic [2:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] op_q;
    logic [7:0] data_q;
    logic [6:0] sect_q;
    logic [7:0] new_byte;
    logic byte_done;
    logic op_done;

    assign new_byte = {shift_q[6:0], si_bit};
    assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
    assign op_done = byte_done & (byte_cnt_q == 3'h0);

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end else if (cs_start) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            shift_q <= new_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            // Saturates so that overlong frames never alias a short one
            if (byte_done && byte_cnt_q != 3'h7) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    // Sector number from A18..A12; A23..A19 are dropped
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            op_q <= 8'h00;
            data_q <= 8'h00;
            sect_q <= 7'h00;
        end else if (byte_done) begin
            if (byte_cnt_q == 3'h0) begin
                op_q <= new_byte;
            end
            if (byte_cnt_q == 3'h1) begin
                data_q <= new_byte;
                sect_q[6:4] <= new_byte[2:0];
            end
            if (byte_cnt_q == 3'h2) begin
                sect_q[3:0] <= new_byte[7:4];
            end
        end
    end

    // ***************************************
    // Status byte and protection decode
    // ***************************************
    logic wel_q;
    logic pd_q;
    logic busy_w;
    logic eng_busy;
    logic eng_done;
    logic [2:0] ps;
    logic side;
    logic lock;
    logic [7:0] status_w;
    logic status_msb;

    assign eng_busy = eng_bus.busy;
    assign eng_done = eng_bus.done;
    assign busy_w = eng_busy | i_array_busy;
    assign ps = eng_bus.nv_bits[2:0];
    assign side = eng_bus.nv_bits[3];
    assign lock = eng_bus.nv_bits[4];
    assign status_w = {lock, 1'b0, side, ps, wel_q, busy_w};
    assign status_msb = status_w[`SFSP_SR_LOCK];

    logic up_lvl;
    logic lo_lvl;
    logic [2:0] up_base;
    logic [2:0] lo_top;
    logic prot_hit;
    assign up_lvl = ~ps[2] & (ps[1:0] != 2'h0);
    assign lo_lvl = ps[2] & side & (ps[1:0] != 2'h0);
    assign up_base = (ps[1:0] == 2'h1) ? `SFSP_UP1_BASE :
                     (ps[1:0] == 2'h2) ? `SFSP_UP2_BASE : `SFSP_UP3_BASE;
    assign lo_top = (ps[1:0] == 2'h1) ? `SFSP_LO1_TOP :
                    (ps[1:0] == 2'h2) ? `SFSP_LO2_TOP : `SFSP_LO3_TOP;
    assign prot_hit = (up_lvl & (sect_q[6:4] >= up_base))
                    | (lo_lvl & (sect_q[6:4] <= lo_top))
                    | (ps[2] & ~lo_lvl);

    // ***************************************
    // Command decode
    // ***************************************
    logic op_rdsr;
    logic op_wren;
    logic op_wrdi;
    logic op_pdn;
    logic op_pdx;
    assign op_rdsr = op_done & (new_byte == `SFSP_OP_RDSR) & ~pd_q;
    assign op_wren = op_done & (new_byte == `SFSP_OP_WREN) & ~pd_q;
    assign op_wrdi = op_done & (new_byte == `SFSP_OP_WRDI) & ~pd_q;
    assign op_pdn = op_done & (new_byte == `SFSP_OP_PDN) & ~pd_q;
    assign op_pdx = op_done & (new_byte == `SFSP_OP_PDX);

    // Writes are judged at chip select rise, on whole bytes only
    logic wr_ok;
    logic go_wrsr;
    logic go_sse;
    logic go_ce;
    assign wr_ok = cs_end & (bit_cnt_q == 3'h0) & wel_q & ~busy_w & ~pd_q;
    assign go_wrsr = wr_ok & (op_q == `SFSP_OP_WRSR) & (byte_cnt_q == `SFSP_LEN_WRSR)
                   & (wp_high | ~lock);
    assign go_sse = wr_ok & ((op_q == `SFSP_OP_SSE_A) | (op_q == `SFSP_OP_SSE_B))
                  & (byte_cnt_q == `SFSP_LEN_SSE) & ~prot_hit;
    assign go_ce = wr_ok & ((op_q == `SFSP_OP_CE_A) | (op_q == `SFSP_OP_CE_B))
                 & (byte_cnt_q == `SFSP_LEN_CE) & (ps == 3'h0);

    assign eng_bus.wrsr_start = go_wrsr;
    assign eng_bus.sse_start = go_sse;
    assign eng_bus.ce_start = go_ce;
    assign eng_bus.wr_bits = {data_q[`SFSP_SR_LOCK], data_q[`SFSP_SR_SIDE],
                              data_q[`SFSP_SR_PS_HI:`SFSP_SR_PS_LO]};

    // ***************************************
    // Write-enable latch and power-down
    // ***************************************
    logic wel_clr_hw;
    logic wel_d;
    logic pd_d;
    assign wel_clr_hw = eng_done | i_array_done;
    // A set arriving with a completion wins; nothing else touches the latch
    assign wel_d = op_wren ? 1'b1 : (op_wrdi | wel_clr_hw) ? 1'b0 : wel_q;
    assign pd_d = pd_q ? ~op_pdx : (op_pdn & ~busy_w);

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            wel_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            wel_q <= wel_d;
            pd_q <= pd_d;
        end
    end

    // ***************************************
    // Status read shifter
    // ***************************************
    logic rd_act_q;
    logic [2:0] rd_idx_q;
    logic so_q;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rd_act_q <= 1'b0;
            rd_idx_q <= 3'h7;
            so_q <= 1'b0;
        end else if (cs_start || cs_end) begin
            rd_act_q <= 1'b0;
        end else if (op_rdsr) begin
            rd_act_q <= 1'b1;
            rd_idx_q <= 3'h7;
        end else if (rd_act_q && sck_fall) begin
            // Live status each bit, so a poll sees busy drop mid-stream
            so_q <= status_w[rd_idx_q];
            rd_idx_q <= rd_idx_q - 3'h1;
        end
    end

    // ***************************************
    // Outputs
    // ***************************************
    logic sse_go_q;
    logic ce_go_q;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            sse_go_q <= 1'b0;
            ce_go_q <= 1'b0;
        end else begin
            sse_go_q <= go_sse;
            ce_go_q <= go_ce;
        end
    end

    assign o_so = so_q;
    assign o_so_oe = rd_act_q & cs_act;
    assign o_sse_go = sse_go_q;
    assign o_chip_erase_go = ce_go_q;
    assign o_erase_sector = sect_q;
    assign o_power_down = pd_q;
    assign o_status = status_w;

    // ***************************************
    // Assertions
    // ***************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    wel_set_a: assert property (op_wren |=> wel_q)
        else $error("write enable did not set the latch");
    wel_clear_a: assert property (op_wrdi |=> !wel_q)
        else $error("write disable did not clear the latch");
    wel_done_a: assert property ((eng_done && !op_wren) |=> !wel_q)
        else $error("latch survived write completion");
    wel_keep_a: assert property ((cs_end && !go_wrsr && !go_sse && !go_ce && !wel_clr_hw)
        |=> wel_q == $past(wel_q))
        else $error("rejected frame changed the latch");
    pd_busy_a: assert property ((op_pdn && busy_w) |=> !pd_q)
        else $error("power-down entered during a write");
    pd_exit_a: assert property ((pd_q && op_pdx) |=> !pd_q)
        else $error("exit byte did not leave power-down");
    pd_block_a: assert property ((pd_q && op_done) |=> !rd_act_q && !go_wrsr)
        else $error("command accepted in power-down");
    rd_first_a: assert property ((rd_act_q && sck_fall && rd_idx_q == 3'h7)
        |=> o_so == $past(status_msb))
        else $error("status read did not start with bit 7");
    rd_wrap_a: assert property ((rd_act_q && sck_fall && rd_idx_q == 3'h0)
        |=> rd_idx_q == 3'h7)
        else $error("status read did not wrap to bit 7");
    rd_busy_a: assert property ((op_done && !pd_q && busy_w
        && shift_q[6:0] == 7'h02 && si_bit) |=> rd_act_q)
        else $error("status read refused while busy");
    lock_hold_a: assert property ((cs_end && op_q == `SFSP_OP_WRSR && lock
        && !wp_high && !eng_busy) |=> !eng_busy)
        else $error("locked status write was started");
    busy_go_a: assert property ((go_wrsr || go_sse) |=> eng_busy [*3])
        else $error("busy not raised with write launch");
    frag_a: assert property ((cs_end && bit_cnt_q != 3'h0 && !eng_busy) |=> !eng_busy)
        else $error("partial byte frame started a write");
    upper_a: assert property ((go_sse && !side && ps == 3'h1) |-> sect_q[6:4] != 3'h7)
        else $error("erase hit the protected upper eighth");
    lower_a: assert property ((go_sse && side && ps == 3'h5) |-> sect_q[6:4] != 3'h0)
        else $error("erase hit the protected lower eighth");
    ce_level_a: assert property (o_chip_erase_go |-> ps == 3'h0 && eng_busy)
        else $error("chip erase with protection set");

    rd_repeat_c: cover property (rd_act_q && sck_fall && rd_idx_q == 3'h0
        ##[1:64] rd_act_q && sck_fall);
    wrsr_done_c: cover property (go_wrsr ##[1:1000] eng_done);
    pd_cycle_c: cover property (pd_q ##[1:1000] !pd_q);
endmodule

// ==== verilog/sfsp_eng_if.sv ====
// Carrier between the command decoder and the internal write engine
`timescale 1ns/1ns
interface sfsp_eng_if;
    logic wrsr_start;
    logic sse_start;
    logic ce_start;
    logic [4:0] wr_bits;
    logic [4:0] nv_bits;
    logic busy;
    logic done;
    modport ctrl(output wrsr_start, sse_start, ce_start, wr_bits, input nv_bits, busy, done);
    modport engine(input wrsr_start, sse_start, ce_start, wr_bits, output nv_bits, busy, done);
endinterface

// ==== verilog/sfsp_map.svh ====
// Opcodes, status bit positions, frame lengths and timing for the status and protect logic
`ifndef SFSP_MAP_SVH
`define SFSP_MAP_SVH
// ***************************************
// Command opcodes
// ***************************************
`define SFSP_OP_WRSR 8'h01
`define SFSP_OP_WRDI 8'h04
`define SFSP_OP_RDSR 8'h05
`define SFSP_OP_WREN 8'h06
`define SFSP_OP_PDN 8'hB9
`define SFSP_OP_PDX 8'hAB
`define SFSP_OP_SSE_A 8'h20
`define SFSP_OP_SSE_B 8'hD7
`define SFSP_OP_CE_A 8'h60
`define SFSP_OP_CE_B 8'hC7
// ***************************************
// Status byte layout and frame lengths in bytes
// ***************************************
`define SFSP_SR_LOCK 7
`define SFSP_SR_SIDE 5
`define SFSP_SR_PS_HI 4
`define SFSP_SR_PS_LO 2
`define SFSP_NV_RESET 5'h00
`define SFSP_LEN_WRSR 3'h2
`define SFSP_LEN_SSE 3'h4
`define SFSP_LEN_CE 3'h1
// Idle pin levels, order {wp_n, si, sck, cs_n}
`define SFSP_PIN_IDLE 4'h9
// ***************************************
// Protect boundaries as address bits 18:16
// ***************************************
`define SFSP_UP1_BASE 3'h7
`define SFSP_UP2_BASE 3'h6
`define SFSP_UP3_BASE 3'h4
`define SFSP_LO1_TOP 3'h0
`define SFSP_LO2_TOP 3'h1
`define SFSP_LO3_TOP 3'h3
// ***************************************
// Timing: clock rate and internal write times
// ***************************************
`define SFSP_CLK_MHZ 125
`define SFSP_T_WRSR_US 5
`define SFSP_T_SSE_US 40
`define SFSP_T_CE_US 200
`define SFSP_CYC(us) ((us) * `SFSP_CLK_MHZ)
`endif

// ==== verilog/sfsp_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module sfsp_pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Pins and filtered view
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, fall_q;
    // A change counts only once stages two and three agree
    assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            lvl_q <= INIT;
            rise_q <= '0;
            fall_q <= '0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            rise_q <= lvl_d & ~lvl_q;
            fall_q <= ~lvl_d & lvl_q;
        end
    end
    assign o_level = lvl_q;
    assign o_rise = rise_q;
    assign o_fall = fall_q;
endmodule

// ==== verilog/sfsp_pkg.sv ====
// Types shared by the status and protect logic
package sfsp_pkg;
    typedef enum {ENG_IDLE, ENG_WRSR, ENG_ERASE} sfsp_eng_state_t;
endpackage

// ==== verilog/sfsp_wr_engine.sv ====
// Internal write engine: nonvolatile status bits and erase/write timers
`timescale 1ns/1ns
module sfsp_wr_engine import sfsp_pkg::*; #(
    parameter int unsigned WRSR_CYCLES = 625,
    parameter int unsigned SSE_CYCLES = 5000,
    parameter int unsigned CE_CYCLES = 25000,
    parameter logic [4:0] NV_RESET = 5'h00
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Decoder side
    sfsp_eng_if.engine bus
);
    sfsp_eng_state_t state_q;
    logic [31:0] cnt_q;
    logic [4:0] nv_q, pend_q;
    logic done_q;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_q <= ENG_IDLE;
            cnt_q <= 32'h0;
            nv_q <= NV_RESET;
            pend_q <= 5'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                ENG_IDLE: begin
                    if (bus.wrsr_start) begin
                        state_q <= ENG_WRSR;
                        cnt_q <= 32'(WRSR_CYCLES - 1);
                        pend_q <= bus.wr_bits;
                    end else if (bus.sse_start) begin
                        state_q <= ENG_ERASE;
                        cnt_q <= 32'(SSE_CYCLES - 1);
                    end else if (bus.ce_start) begin
                        state_q <= ENG_ERASE;
                        cnt_q <= 32'(CE_CYCLES - 1);
                    end
                end
                ENG_WRSR, ENG_ERASE: begin
                    if (cnt_q == 32'h0) begin
                        state_q <= ENG_IDLE;
                        done_q <= 1'b1;
                        // Erase and reprogram happen as one step at the end
                        if (state_q == ENG_WRSR) begin
                            nv_q <= pend_q;
                        end
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
            endcase
        end
    end
    assign bus.busy = (state_q != ENG_IDLE);
    assign bus.done = done_q;
    assign bus.nv_bits = nv_q;
endmodule
